//--- bench/test_uxc_reg_bank.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module test_uxc_reg_bank;
    import uxc_pkg::*;
    // ****************************************
    // stimulus and checks
    // ****************************************
    typedef struct packed {logic [7:0] l, a, d, e;} uxc_row_t;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    uxc_req_t    req;
    uxc_fifo_t   fs = '0;
    logic [7:0]  rd;
    logic [15:0] dv;
    logic [7:0]  hc1, hc2, rc1, rc2;
    logic        pre, slp, rts, txr, rxr;
    int          fails = 0;
    int          n_checks = 0;
    uxc_row_t    rows [10] = '{
        '{8'h80, 8'h00, 8'h5A, 8'h5A}, '{8'h80, 8'h01, 8'hC3, 8'hC3},
        '{8'hBF, 8'h02, 8'h10, 8'h10}, '{8'hBF, 8'h06, 8'h11, 8'h11},
        '{8'hBF, 8'h05, 8'h22, 8'h22}, '{8'hBF, 8'h04, 8'h33, 8'h33},
        '{8'hBF, 8'h07, 8'h44, 8'h44}, '{8'h00, 8'h04, 8'hC0, 8'hC0},
        '{8'h00, 8'h06, 8'h48, 8'h48},
        '{8'h00, 8'h07, 8'h21, 8'h21}};
    uxc_host_model u_h (.mclk(mclk), .req(req));
    uxc_reg_bank u_dut (.mclk(mclk), .sys_rst(sys_rst), .host_req(req),
        .rdata_r(rd), .fifo_stat(fs), .peer_tx_rdy(3'h5),
        .peer_rx_rdy(3'h2), .divisor_r(dv), .prescale_div4_r(pre),
        .sleep_en_r(slp), .halt_char_one_r(hc1), .halt_char_two_r(hc2),
        .resume_char_one_r(rc1), .resume_char_two_r(rc2), .rts_r(rts),
        .tx_ready_r(txr), .rx_ready_r(rxr));
    // 50 ns clock
    initial forever #25 mclk = ~mclk;
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (e !== g) begin
            fails++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic rdc(logic [2:0] a, logic [7:0] e);
        u_h.rd(a);
        #1 chk("rdata", {8'h00, e}, {8'h00, rd});
    endtask : rdc
    // fifo levels, then settle two edges
    task automatic lvl(logic [6:0] t, logic [6:0] r, logic o);
        @(posedge mclk);
        fs <= '{tx_free: t, rx_fill: r, rx_timeout: o};
        repeat (2) @(posedge mclk);
        #1;
    endtask : lvl
    task automatic close_out;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    // watchdog
    initial begin
        repeat (3000) @(posedge mclk);
        fails++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        #1 chk("div", 16'h0000, dv);
        chk("rts", 1, rts);
        lvl(7'd8, 7'd9, 1'b0);
        chk("rdy", 2'b11, {txr, rxr});
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            u_h.wr(3'h3, rows[i].l);
            u_h.wr(rows[i].a[2:0], rows[i].d);
            rdc(rows[i].a[2:0], rows[i].e);
        end
        chk("div", 16'hC35A, dv);
        chk("pre", 1, pre);
        chk("halt", 16'h1144, {hc1, hc2});
        chk("resume", 16'h3322, {rc1, rc2});
        // automatic request only after the thresholds are loaded
        u_h.wr(3'h3, 8'hBF);
        u_h.wr(3'h2, 8'h50);
        u_h.wr(3'h3, 8'h00);
        $display("test rows done");
        lvl(7'd0, 7'd31, 1'b0);
        chk("rts", 0, rts);
        lvl(7'd0, 7'd32, 1'b0);
        chk("rts", 1, rts);
        lvl(7'd0, 7'd17, 1'b0);
        chk("rts", 1, rts);
        lvl(7'd0, 7'd16, 1'b0);
        chk("rts", 0, rts);
        lvl(7'd4, 7'd9, 1'b0);
        chk("rdy", 2'b11, {txr, rxr});
        lvl(7'd3, 7'd8, 1'b0);
        chk("rdy", 2'b00, {txr, rxr});
        lvl(7'd3, 7'd8, 1'b1);
        chk("rdy", 2'b01, {txr, rxr});
        lvl(7'd4, 7'd9, 1'b0);
        u_h.wr(3'h4, 8'h04);
        rdc(3'h7, 8'h5B);
        $display("test flow done");
        u_h.wr(3'h4, 8'hC0);
        u_h.wr(3'h7, 8'h00);
        lvl(7'd7, 7'd9, 1'b0);
        chk("rdy", 2'b01, {txr, rxr});
        lvl(7'd8, 7'd8, 1'b0);
        chk("rdy", 2'b10, {txr, rxr});
        // fifo control picks 16 for both directions
        u_h.wr(3'h2, 8'h50);
        lvl(7'd15, 7'd16, 1'b0);
        chk("rdy", 2'b00, {txr, rxr});
        u_h.wr(3'h1, 8'h10);
        #1 chk("slp", 1, slp);
        u_h.wr(3'h3, 8'h80);
        u_h.wr(3'h0, 8'h00);
        #1 chk("div", 16'hC35A, dv);
        u_h.wr(3'h3, 8'hBF);
        u_h.wr(3'h2, 8'h00);
        u_h.wr(3'h3, 8'h00);
        u_h.wr(3'h4, 8'h00);
        rdc(3'h4, 8'hC0);
        u_h.wr(3'h6, 8'hFF);
        rdc(3'h6, 8'h48);
        $display("test refusals done");
        close_out();
    end
endmodule : test_uxc_reg_bank
`default_nettype wire

//--- bench/uxc_host_model.sv
// host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module uxc_host_model (
    // clock
    input  wire logic         mclk,
    // register port
    output uxc_pkg::uxc_req_t req
);
    import uxc_pkg::*;
    // ****************************************
    // bus cycles, one strobe cycle each
    // ****************************************
    initial req = '0;
    // write strobe for one edge, then idle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{cs: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req <= '0;
    endtask : wr
    // read strobe; data is registered on the release edge
    task automatic rd(input logic [2:0] a);
        @(posedge mclk);
        req <= '{cs: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        req <= '0;
    endtask : rd
endmodule : uxc_host_model
`default_nettype wire

//--- common/uxc_defs.svh
// constants for the extended configuration register bank
// Function
// - divisor is sixteen bits, held as a low byte and a high byte
// - divisor bytes take writes only while sleep enable is clear
// - flow threshold low nibble sets receive fill that halts sending
// - flow threshold high nibble sets receive fill that resumes sending
// - each flow threshold nibble means nibble times four bytes, 0 to 60
// - flow threshold takes writes only with enhanced and extended bits set
// - trigger low nibble sets transmit trigger in free spaces, 4 to 60
// - trigger high nibble sets receive trigger level, steps of four
// - trigger register takes writes only with enhanced and extended bits
// - zero trigger nibble falls back to fifo control choice per direction
// - ready low bits: transmit fifo has at least trigger free spaces
// - ready high bits: receive fill above trigger, or receive timeout
// - ready status is read only at offset 7 with enable, no loopback
// - enhanced mode maps 6, 4 to first halt, resume; 2 to enhanced
// - enhanced mode maps offsets 7 and 5 to second halt and resume
// - extended access bit outside enhanced mode maps offset 6 to threshold
// - extended access maps 7 to trigger; ready enable maps 7 to status
// - modem control bit 7 picks divide by four; enhanced gated write
// - enhanced enable guards interrupt 7:4, fifo 5:4, modem 7:5 bits
// - automatic request raises at halt level, drops at restore level
`ifndef UXC_DEFS_SVH
`define UXC_DEFS_SVH
// register offsets
`define UXC_OFF_0        3'h0
`define UXC_OFF_1        3'h1
`define UXC_OFF_2        3'h2
`define UXC_OFF_3        3'h3
`define UXC_OFF_4        3'h4
`define UXC_OFF_5        3'h5
`define UXC_OFF_6        3'h6
`define UXC_OFF_7        3'h7
// line control codes and bits
`define UXC_LCR_ENH      8'hBF
`define UXC_LCR_DIV_BIT  7
// enhanced feature bits
`define UXC_EFR_ENH_BIT  4
`define UXC_EFR_ARTS_BIT 6
// modem control bits
`define UXC_MCR_RTS_BIT  1
`define UXC_MCR_FRR_BIT  2
`define UXC_MCR_LOOP_BIT 4
`define UXC_MCR_EXT_BIT  6
`define UXC_MCR_PRE_BIT  7
// interrupt enable bits
`define UXC_IER_SLP_BIT  4
// masks of bits guarded by enhanced enable
`define UXC_IER_GUARD    8'hF0
`define UXC_FCR_GUARD    8'h30
`define UXC_MCR_GUARD    8'hE0
// reset values
`define UXC_RST_BYTE     8'h00
`define UXC_RST_DIV      16'h0000
// fallback trigger levels picked by fifo control (tx 5:4, rx 7:6)
`define UXC_FCR_TX_LVL   {6'h38, 6'h20, 6'h10, 6'h08}
`define UXC_FCR_RX_LVL   {6'h3C, 6'h38, 6'h10, 6'h08}
`endif

//--- common/uxc_pkg.sv
// types shared by the extended configuration register bank
package uxc_pkg;
    // host register access carried as one bundle
    typedef struct packed {
        logic       cs;
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } uxc_req_t;
    // fifo fill state from the datapath
    typedef struct packed {
        logic [6:0] tx_free;
        logic [6:0] rx_fill;
        logic       rx_timeout;
    } uxc_fifo_t;
    // register window selected by line control
    typedef enum logic [1:0] {
        UXC_WIN_NORM,
        UXC_WIN_DIV,
        UXC_WIN_ENH
    } uxc_win_t;
    // automatic request-to-send state
    typedef enum logic {
        UXC_RTS_FLOW,
        UXC_RTS_HALT
    } uxc_rts_t;
endpackage : uxc_pkg

//--- core/uxc_level_unit.sv
// trigger resolution, fifo ready flags and automatic request-to-send
`timescale 1ns/1ps
`default_nettype none
`include "uxc_defs.svh"
module uxc_level_unit (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // configuration
    input  wire logic [7:0]       flow_threshold,
    input  wire logic [7:0]       fifo_trigger_level,
    input  wire logic [7:0]       fifo_control,
    input  wire logic             arts_en,
    input  wire logic             rts_bit,
    // fifo state
    input  wire uxc_pkg::uxc_fifo_t fifo,
    // results
    output logic                  tx_ready_r,
    output logic                  rx_ready_r,
    output logic                  rts_r
);
    import uxc_pkg::*;

    // ****************************************************************
    // level arithmetic
    // ****************************************************************
    // nibble to byte level, steps of four
    function automatic logic [6:0] nib_lvl(input logic [3:0] n);
        nib_lvl = {1'b0, n, 2'b00};
    endfunction : nib_lvl

    localparam logic [23:0] TX_TAB = `UXC_FCR_TX_LVL;
    localparam logic [23:0] RX_TAB = `UXC_FCR_RX_LVL;

    wire logic [6:0] halt_lvl    = nib_lvl(flow_threshold[3:0]);
    wire logic [6:0] restore_lvl = nib_lvl(flow_threshold[7:4]);
    wire logic [6:0] tx_fcr = {1'b0, TX_TAB[6*fifo_control[5:4] +: 6]};
    wire logic [6:0] rx_fcr = {1'b0, RX_TAB[6*fifo_control[7:6] +: 6]};
    // zero nibble falls back to fifo control choice
    wire logic [6:0] tx_trig = (fifo_trigger_level[3:0] == 4'h0) ? tx_fcr
                                                  : nib_lvl(fifo_trigger_level[3:0]);
    wire logic [6:0] rx_trig = (fifo_trigger_level[7:4] == 4'h0) ? rx_fcr
                                                  : nib_lvl(fifo_trigger_level[7:4]);
    wire logic tx_rdy_nxt = fifo.tx_free >= tx_trig;
    wire logic rx_rdy_nxt = (fifo.rx_fill > rx_trig)
                          | fifo.rx_timeout;

    // ****************************************************************
    // flow state
    // ****************************************************************
    uxc_rts_t rts_st_r;
    uxc_rts_t rts_st_nxt;

    // halt at halt level, resume at restore level
    always_comb begin
        case (rts_st_r)
            UXC_RTS_FLOW: rts_st_nxt = (fifo.rx_fill >= halt_lvl)
                                     ? UXC_RTS_HALT : UXC_RTS_FLOW;
            UXC_RTS_HALT: rts_st_nxt = (fifo.rx_fill <= restore_lvl)
                                     ? UXC_RTS_FLOW : UXC_RTS_HALT;
            default:      rts_st_nxt = UXC_RTS_FLOW;
        endcase
    end

    // registered flags and pin
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rts_st_r   <= UXC_RTS_FLOW;
            tx_ready_r <= 1'b0;
            rx_ready_r <= 1'b0;
            rts_r      <= 1'b1;
        end else begin
            rts_st_r   <= arts_en ? rts_st_nxt : UXC_RTS_FLOW;
            tx_ready_r <= tx_rdy_nxt;
            rx_ready_r <= rx_rdy_nxt;
            rts_r      <= arts_en ? (rts_st_nxt == UXC_RTS_HALT) : ~rts_bit;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_rts_halt;
        @(posedge mclk) disable iff (sys_rst)
        (arts_en && fifo.rx_fill >= halt_lvl) |=> rts_r;
    endproperty
    a_rts_halt: assert property (p_rts_halt)
        else $error("request not raised at halt level");

    property p_rx_rdy;
        @(posedge mclk) disable iff (sys_rst)
        (fifo.rx_timeout || fifo.rx_fill > rx_trig) |=> rx_ready_r;
    endproperty
    a_rx_rdy: assert property (p_rx_rdy)
        else $error("receive ready missing");

    property p_tx_zero;
        @(posedge mclk) disable iff (sys_rst)
        (fifo_trigger_level[3:0] == 4'h0 && fifo.tx_free < tx_fcr) |=> !tx_ready_r;
    endproperty
    a_tx_zero: assert property (p_tx_zero)
        else $error("transmit ready ignores fallback level");
endmodule : uxc_level_unit
`default_nettype wire

//--- core/uxc_reg_bank.sv
// extended configuration register bank of one serial channel
`timescale 1ns/1ps
`default_nettype none
`include "uxc_defs.svh"
module uxc_reg_bank (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    // host register port
    input  wire uxc_pkg::uxc_req_t  host_req,
    output logic [7:0]              rdata_r,
    // fifo state and the other channels' ready bits
    input  wire uxc_pkg::uxc_fifo_t fifo_stat,
    input  wire logic [2:0]         peer_tx_rdy,
    input  wire logic [2:0]         peer_rx_rdy,
    // configuration towards the channel
    output logic [15:0]             divisor_r,
    output logic                    prescale_div4_r,
    output logic                    sleep_en_r,
    output logic [7:0]              halt_char_one_r,
    output logic [7:0]              halt_char_two_r,
    output logic [7:0]              resume_char_one_r,
    output logic [7:0]              resume_char_two_r,
    // flow and ready state
    output logic                    rts_r,
    output logic                    tx_ready_r,
    output logic                    rx_ready_r
);
    import uxc_pkg::*;

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [7:0] line_control_r;
    logic [7:0] modem_control_r;
    logic [7:0] enhanced_feature_control_r;
    logic [7:0] interrupt_enable_r;
    logic [7:0] fifo_control_r;
    logic [7:0] flow_threshold_r;
    logic [7:0] fifo_trigger_level_r;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // guarded bits keep their value unless enhanced enable is set
    function automatic logic [7:0] guard_wr(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] mask,
                                            input logic       en);
        guard_wr = en ? new_v : ((old_v & mask) | (new_v & ~mask));
    endfunction : guard_wr

    // ****************************************************************
    // window and address decode
    // ****************************************************************
    uxc_win_t win;
    wire logic [2:0] a       = host_req.addr;
    wire logic       wr_acc  = host_req.cs & host_req.wr;
    wire logic       rd_acc  = host_req.cs & host_req.rd;
    wire logic       enh_on  = enhanced_feature_control_r[`UXC_EFR_ENH_BIT];
    wire logic       ext_on  = modem_control_r[`UXC_MCR_EXT_BIT];
    wire logic       frr_on  = modem_control_r[`UXC_MCR_FRR_BIT];
    wire logic       loop_on = modem_control_r[`UXC_MCR_LOOP_BIT];
    wire logic       sleep_on = interrupt_enable_r[`UXC_IER_SLP_BIT];

    // line control picks the window
    always_comb begin
        if (line_control_r == `UXC_LCR_ENH)
            win = UXC_WIN_ENH;
        else if (line_control_r[`UXC_LCR_DIV_BIT])
            win = UXC_WIN_DIV;
        else
            win = UXC_WIN_NORM;
    end

    wire logic div_w  = (win != UXC_WIN_NORM);     // divisor bit is set
    wire logic enh_w  = (win == UXC_WIN_ENH);
    wire logic norm_w = (win == UXC_WIN_NORM);

    // register selects
    wire logic sel_dll  = div_w & (a == `UXC_OFF_0);
    wire logic sel_dlh  = div_w & (a == `UXC_OFF_1);
    wire logic sel_ier  = norm_w & (a == `UXC_OFF_1);
    wire logic sel_fcr  = !enh_w & (a == `UXC_OFF_2);
    wire logic sel_efr  = enh_w & (a == `UXC_OFF_2);
    wire logic sel_lcr  = (a == `UXC_OFF_3);
    wire logic sel_mcr  = !enh_w & (a == `UXC_OFF_4);
    wire logic sel_resume_char_one = enh_w & (a == `UXC_OFF_4);
    wire logic sel_resume_char_two = enh_w & (a == `UXC_OFF_5);
    wire logic sel_xof1 = enh_w & (a == `UXC_OFF_6);
    wire logic sel_xof2 = enh_w & (a == `UXC_OFF_7);
    wire logic sel_tcr  = !enh_w & ext_on
                        & (a == `UXC_OFF_6);
    wire logic sel_tlr  = !enh_w & ext_on
                        & (a == `UXC_OFF_7);
    wire logic sel_frr  = !enh_w & !ext_on & frr_on & !loop_on
                        & (a == `UXC_OFF_7);

    // write enables with their gates
    wire logic we_div  = wr_acc & !sleep_on;
    wire logic we_ext  = wr_acc & enh_on;
    wire logic we_dll  = we_div & sel_dll;
    wire logic we_dlh  = we_div & sel_dlh;
    wire logic we_tcr  = we_ext & sel_tcr;
    wire logic we_tlr  = we_ext & sel_tlr;

    // guarded next values
    wire logic [7:0] ier_nxt = guard_wr(interrupt_enable_r, host_req.wdata,
                                        `UXC_IER_GUARD, enh_on);
    wire logic [7:0] fcr_nxt = guard_wr(fifo_control_r, host_req.wdata,
                                        `UXC_FCR_GUARD, enh_on);
    wire logic [7:0] mcr_nxt = guard_wr(modem_control_r, host_req.wdata,
                                        `UXC_MCR_GUARD, enh_on);

    // ready view: this channel in bits 0 and 4
    wire logic [7:0] frr_view = {peer_rx_rdy, rx_ready_r,
                                 peer_tx_rdy, tx_ready_r};

    // ****************************************************************
    // read multiplexer
    // ****************************************************************
    logic [7:0] rd_nxt;

    // unmapped or write-only offsets read as zero
    always_comb begin
        rd_nxt = `UXC_RST_BYTE;
        if (sel_dll)
            rd_nxt = divisor_r[7:0];
        else if (sel_dlh)
            rd_nxt = divisor_r[15:8];
        else if (sel_ier)
            rd_nxt = interrupt_enable_r;
        else if (sel_efr)
            rd_nxt = enhanced_feature_control_r;
        else if (sel_lcr)
            rd_nxt = line_control_r;
        else if (sel_mcr)
            rd_nxt = modem_control_r;
        else if (sel_resume_char_one)
            rd_nxt = resume_char_one_r;
        else if (sel_resume_char_two)
            rd_nxt = resume_char_two_r;
        else if (sel_xof1)
            rd_nxt = halt_char_one_r;
        else if (sel_xof2)
            rd_nxt = halt_char_two_r;
        else if (sel_tcr)
            rd_nxt = flow_threshold_r;
        else if (sel_tlr)
            rd_nxt = fifo_trigger_level_r;
        else if (sel_frr)
            rd_nxt = frr_view;
    end

    // read data register, updated on each read strobe
    always_ff @(posedge mclk) begin
        if (sys_rst)
            rdata_r <= `UXC_RST_BYTE;
        else if (rd_acc)
            rdata_r <= rd_nxt;
    end

    // ****************************************************************
    // divisor bytes
    // ****************************************************************
    // two byte halves of the baud divisor
    always_ff @(posedge mclk) begin
        if (sys_rst)
            divisor_r <= `UXC_RST_DIV;
        else if (we_dll)
            divisor_r[7:0] <= host_req.wdata;
        else if (we_dlh)
            divisor_r[15:8] <= host_req.wdata;
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    // line, modem, enhanced, interrupt enable and fifo control
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            line_control_r             <= `UXC_RST_BYTE;
            modem_control_r            <= `UXC_RST_BYTE;
            enhanced_feature_control_r <= `UXC_RST_BYTE;
            interrupt_enable_r         <= `UXC_RST_BYTE;
            fifo_control_r             <= `UXC_RST_BYTE;
        end else if (wr_acc) begin
            if (sel_lcr)
                line_control_r <= host_req.wdata;
            if (sel_mcr)
                modem_control_r <= mcr_nxt;
            if (sel_efr)
                enhanced_feature_control_r <= host_req.wdata;
            if (sel_ier)
                interrupt_enable_r <= ier_nxt;
            if (sel_fcr)
                fifo_control_r <= fcr_nxt;
        end
    end

    // ****************************************************************
    // flow characters
    // ****************************************************************
    // halt and resume characters, enhanced window only
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            resume_char_one_r <= `UXC_RST_BYTE;
            resume_char_two_r <= `UXC_RST_BYTE;
            halt_char_one_r   <= `UXC_RST_BYTE;
            halt_char_two_r   <= `UXC_RST_BYTE;
        end else if (wr_acc) begin
            if (sel_resume_char_one)
                resume_char_one_r <= host_req.wdata;
            if (sel_resume_char_two)
                resume_char_two_r <= host_req.wdata;
            if (sel_xof1)
                halt_char_one_r <= host_req.wdata;
            if (sel_xof2)
                halt_char_two_r <= host_req.wdata;
        end
    end

    // ****************************************************************
    // thresholds and trigger levels
    // ****************************************************************
    // zero after reset so fifo control levels apply
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flow_threshold_r     <= `UXC_RST_BYTE;
            fifo_trigger_level_r <= `UXC_RST_BYTE;
        end else begin
            if (we_tcr)
                flow_threshold_r <= host_req.wdata;
            if (we_tlr)
                fifo_trigger_level_r <= host_req.wdata;
        end
    end

    // ****************************************************************
    // outputs taken from control flops
    // ****************************************************************
    assign prescale_div4_r = modem_control_r[`UXC_MCR_PRE_BIT];
    assign sleep_en_r      = interrupt_enable_r[`UXC_IER_SLP_BIT];

    // level resolution and flow control
    uxc_level_unit u_level (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .flow_threshold        (flow_threshold_r),
        .fifo_trigger_level        (fifo_trigger_level_r),
        .fifo_control        (fifo_control_r),
        .arts_en    (enhanced_feature_control_r[`UXC_EFR_ARTS_BIT]),
        .rts_bit    (modem_control_r[`UXC_MCR_RTS_BIT]),
        .fifo       (fifo_stat),
        .tx_ready_r (tx_ready_r),
        .rx_ready_r (rx_ready_r),
        .rts_r      (rts_r)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_div_lock;
        @(posedge mclk) disable iff (sys_rst)
        (wr_acc && sleep_on) |=> $stable(divisor_r);
    endproperty
    a_div_lock: assert property (p_div_lock)
        else $error("divisor written during sleep");

    property p_dll_wr;
        @(posedge mclk) disable iff (sys_rst)
        (wr_acc && !sleep_on && line_control_r[`UXC_LCR_DIV_BIT]
         && a == `UXC_OFF_0) |=> divisor_r[7:0] == $past(host_req.wdata);
    endproperty
    a_dll_wr: assert property (p_dll_wr)
        else $error("divisor low byte not written");

    property p_tcr_lock;
        @(posedge mclk) disable iff (sys_rst)
        (!(enh_on && ext_on)) |=> $stable(flow_threshold_r);
    endproperty
    a_tcr_lock: assert property (p_tcr_lock)
        else $error("threshold written without access bits");

    property p_tlr_lock;
        @(posedge mclk) disable iff (sys_rst)
        (!enh_on || !ext_on || enh_w) |=> $stable(fifo_trigger_level_r);
    endproperty
    a_tlr_lock: assert property (p_tlr_lock)
        else $error("trigger written without access bits");

    property p_ier_guard;
        @(posedge mclk) disable iff (sys_rst)
        !enh_on |=> $stable(interrupt_enable_r[7:4]);
    endproperty
    a_ier_guard: assert property (p_ier_guard)
        else $error("guarded interrupt enable bits changed");

    property p_pre_guard;
        @(posedge mclk) disable iff (sys_rst)
        !enh_on |=> $stable(prescale_div4_r);
    endproperty
    a_pre_guard: assert property (p_pre_guard)
        else $error("prescaler changed without enhanced enable");

    property p_frr_rd;
        @(posedge mclk) disable iff (sys_rst)
        (rd_acc && norm_w && !ext_on && frr_on && !loop_on
         && a == `UXC_OFF_7) |=> rdata_r == $past(frr_view);
    endproperty
    a_frr_rd: assert property (p_frr_rd)
        else $error("ready status read wrong");

    property p_xof1_wr;
        @(posedge mclk) disable iff (sys_rst)
        (wr_acc && line_control_r == `UXC_LCR_ENH && a == `UXC_OFF_6)
        |=> halt_char_one_r == $past(host_req.wdata) ##1
            $stable(flow_threshold_r);
    endproperty
    a_xof1_wr: assert property (p_xof1_wr)
        else $error("first halt character not written");

    property p_dlh_wr;
        @(posedge mclk) disable iff (sys_rst)
        (wr_acc && !sleep_on && line_control_r[`UXC_LCR_DIV_BIT]
         && a == `UXC_OFF_1) |=> divisor_r[15:8] == $past(host_req.wdata);
    endproperty
    a_dlh_wr: assert property (p_dlh_wr)
        else $error("divisor high byte not written");

    property p_tcr_wr;
        @(posedge mclk) disable iff (sys_rst)
        (wr_acc && enh_on && ext_on && !enh_w && a == `UXC_OFF_6)
        |=> flow_threshold_r == $past(host_req.wdata);
    endproperty
    a_tcr_wr: assert property (p_tcr_wr)
        else $error("threshold write did not land");

    property p_tlr_wr;
        @(posedge mclk) disable iff (sys_rst)
        (wr_acc && enh_on && ext_on && !enh_w && a == `UXC_OFF_7)
        |=> fifo_trigger_level_r == $past(host_req.wdata);
    endproperty
    a_tlr_wr: assert property (p_tlr_wr)
        else $error("trigger write did not land");

    property p_resume_char_one_wr;
        @(posedge mclk) disable iff (sys_rst)
        (wr_acc && line_control_r == `UXC_LCR_ENH && a == `UXC_OFF_4)
        |=> resume_char_one_r == $past(host_req.wdata);
    endproperty
    a_resume_char_one_wr: assert property (p_resume_char_one_wr)
        else $error("first resume character not written");
endmodule : uxc_reg_bank
`default_nettype wire
